// File: verilog/lane_char_scrambler_config.sv
// Character and scrambler configuration bank with its data paths
`timescale 1ns/1ps
module lane_char_scrambler_config #(
  parameter int ADDR_W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Transmit: user data to encoder, encoder word to line
  input wire logic [15:0] tx_in_data,
  input wire logic tx_in_valid,
  output logic [15:0] tx_to_enc_data,
  output logic tx_to_enc_valid,
  input wire logic [19:0] tx_from_enc_data,
  input wire logic tx_from_enc_valid,
  output logic [19:0] tx_line_data,
  output logic tx_line_valid,
  // Receive: line word to decoder, decoder data to user
  input wire logic [19:0] rx_line_data,
  input wire logic rx_line_valid,
  output logic [19:0] rx_to_dec_data,
  output logic rx_to_dec_valid,
  input wire logic [15:0] rx_from_dec_data,
  input wire logic rx_from_dec_valid,
  output logic [15:0] rx_out_data,
  output logic rx_out_valid,
  // Idle characters for the framing logic
  output logic [9:0] tx_idle_positive,
  output logic [9:0] tx_idle_negative,
  output logic [9:0] rx_idle_positive,
  output logic [9:0] rx_idle_negative
);

  localparam int N = lane_char_pkg::EXT_REGS;
  localparam int CW = lane_char_pkg::CHAR_W;

  // Extended register file and pointer
  logic [15:0] cfg_q [N];
  logic [15:0] indirect_address_pointer_q;

  // Write channel state
  logic aw_held_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic w_held_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;

  // Read channel state
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  logic wr_fire;
  logic wr_to_pointer;
  logic wr_to_data;
  logic ext_hit;
  logic [4:0] ext_slot;
  logic [15:0] ext_rd;
  logic [15:0] indirect_data_port;

  // Lane-merge the low 16 bits of a write under its strobes
  function automatic logic [15:0] merge16(
    input logic [15:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] strb
  );
    logic [15:0] r;
    r = old_val;
    if (strb[0]) begin
      r[7:0] = new_val[7:0];
    end
    if (strb[1]) begin
      r[15:8] = new_val[15:8];
    end
    return r;
  endfunction : merge16

  // Extended address lookup
  always_comb begin
    ext_hit = 1'b0;
    ext_slot = 5'h00;
    for (int i = 0; i < N; i++) begin
      if (indirect_address_pointer_q == lane_char_pkg::EXT_OFFSET[i]) begin
        ext_hit = 1'b1;
        ext_slot = 5'(i);
      end
    end
  end

  // Unknown extended addresses read as zero
  assign ext_rd = ext_hit ? cfg_q[ext_slot] : 16'h0000;
  assign indirect_data_port = ext_rd;

  // ---------------- Write path ----------------
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign wr_to_pointer = wr_fire &&
    (aw_addr_q == ADDR_W'(lane_char_pkg::ADDR_POINTER));
  assign wr_to_data = wr_fire &&
    (aw_addr_q == ADDR_W'(lane_char_pkg::ADDR_DATA));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= lane_char_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= (wr_to_pointer || wr_to_data) ?
        lane_char_pkg::RESP_OKAY : lane_char_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      indirect_address_pointer_q <= lane_char_pkg::POINTER_RESET;
    end else if (wr_to_pointer) begin
      indirect_address_pointer_q <=
        merge16(indirect_address_pointer_q, w_data_q, w_strb_q);
    end
  end

  // Each slot keeps its reset value and masks out fixed or unused bits
  for (genvar g = 0; g < N; g++) begin : g_cfg
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cfg_q[g] <= lane_char_pkg::EXT_RESET[g];
      end else if (wr_to_data && ext_hit && ext_slot == 5'(g)) begin
        cfg_q[g] <= merge16(cfg_q[g], w_data_q, w_strb_q) &
          lane_char_pkg::EXT_MASK[g];
      end
    end
  end

  // ---------------- Read path ----------------
  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= lane_char_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      if (s_axi_araddr == ADDR_W'(lane_char_pkg::ADDR_POINTER)) begin
        rdata_q <= {16'h0000, indirect_address_pointer_q};
        rresp_q <= lane_char_pkg::RESP_OKAY;
      end else if (s_axi_araddr == ADDR_W'(lane_char_pkg::ADDR_DATA)) begin
        rdata_q <= {16'h0000, indirect_data_port};
        rresp_q <= lane_char_pkg::RESP_OKAY;
      end else begin
        rdata_q <= 32'h0000_0000;
        rresp_q <= lane_char_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ---------------- Configuration fields ----------------
  logic [CW-1:0] tx_search_marker;
  logic [CW-1:0] tx_replace_marker;
  logic [CW-1:0] rx_search_marker;
  logic [CW-1:0] rx_replace_marker;
  logic tx_pre_encode_scramble_on;
  logic tx_post_encode_scramble_on;
  logic rx_pre_decode_descramble_on;
  logic rx_post_decode_descramble_on;
  logic [31:0] tx_scramble_seed;
  logic [31:0] tx_scramble_polynomial;
  logic [31:0] rx_descramble_seed;
  logic [31:0] rx_descramble_polynomial;

  assign tx_search_marker = cfg_q[lane_char_pkg::S_TX_SEARCH][CW-1:0];
  assign tx_replace_marker = cfg_q[lane_char_pkg::S_TX_REPLACE][CW-1:0];
  assign rx_search_marker = cfg_q[lane_char_pkg::S_RX_SEARCH][CW-1:0];
  assign rx_replace_marker = cfg_q[lane_char_pkg::S_RX_REPLACE][CW-1:0];

  assign tx_idle_positive = cfg_q[lane_char_pkg::S_TX_IDLE_P][CW-1:0];
  assign tx_idle_negative = cfg_q[lane_char_pkg::S_TX_IDLE_N][CW-1:0];
  assign rx_idle_positive = cfg_q[lane_char_pkg::S_RX_IDLE_P][CW-1:0];
  assign rx_idle_negative = cfg_q[lane_char_pkg::S_RX_IDLE_N][CW-1:0];

  assign tx_pre_encode_scramble_on =
    cfg_q[lane_char_pkg::S_TX_CTRL][lane_char_pkg::CTRL_PRE_BIT];
  assign tx_post_encode_scramble_on =
    cfg_q[lane_char_pkg::S_TX_CTRL][lane_char_pkg::CTRL_POST_BIT];
  assign rx_post_decode_descramble_on =
    cfg_q[lane_char_pkg::S_RX_CTRL][lane_char_pkg::CTRL_PRE_BIT];
  assign rx_pre_decode_descramble_on =
    cfg_q[lane_char_pkg::S_RX_CTRL][lane_char_pkg::CTRL_POST_BIT];

  assign tx_scramble_seed = {cfg_q[lane_char_pkg::S_TX_SEED_HI],
    cfg_q[lane_char_pkg::S_TX_SEED_LO]};
  assign tx_scramble_polynomial = {cfg_q[lane_char_pkg::S_TX_POLY_HI],
    cfg_q[lane_char_pkg::S_TX_POLY_LO]};
  assign rx_descramble_seed = {cfg_q[lane_char_pkg::S_RX_SEED_HI],
    cfg_q[lane_char_pkg::S_RX_SEED_LO]};
  assign rx_descramble_polynomial = {cfg_q[lane_char_pkg::S_RX_POLY_HI],
    cfg_q[lane_char_pkg::S_RX_POLY_LO]};

  // ---------------- Transmit path ----------------
  logic [19:0] tx_post_data;
  logic tx_post_valid;

  // Pre-encoder scrambler, seed reloaded while off
  lfsr_scrambler #(.W(16)) u_tx_pre (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(tx_pre_encode_scramble_on),
    .seed(tx_scramble_seed),
    .poly(tx_scramble_polynomial),
    .in_data(tx_in_data),
    .in_valid(tx_in_valid),
    .out_data(tx_to_enc_data),
    .out_valid(tx_to_enc_valid)
  );

  // Post-encoder scrambler, bypassed while off
  lfsr_scrambler #(.W(20)) u_tx_post (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(tx_post_encode_scramble_on),
    .seed(tx_scramble_seed),
    .poly(tx_scramble_polynomial),
    .in_data(tx_from_enc_data),
    .in_valid(tx_from_enc_valid),
    .out_data(tx_post_data),
    .out_valid(tx_post_valid)
  );

  // Markers swapped last so they leave unscrambled
  marker_replacer #(.CHARS(2), .CW(CW)) u_tx_marker (
    .aclk(aclk),
    .aresetn(aresetn),
    .search(tx_search_marker),
    .replace(tx_replace_marker),
    .in_data(tx_post_data),
    .in_valid(tx_post_valid),
    .out_data(tx_line_data),
    .out_valid(tx_line_valid)
  );

  // ---------------- Receive path ----------------
  logic [19:0] rx_swap_data;
  logic rx_swap_valid;

  // Markers swapped first, before any descrambling
  marker_replacer #(.CHARS(2), .CW(CW)) u_rx_marker (
    .aclk(aclk),
    .aresetn(aresetn),
    .search(rx_search_marker),
    .replace(rx_replace_marker),
    .in_data(rx_line_data),
    .in_valid(rx_line_valid),
    .out_data(rx_swap_data),
    .out_valid(rx_swap_valid)
  );

  lfsr_scrambler #(.W(20)) u_rx_pre (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(rx_pre_decode_descramble_on),
    .seed(rx_descramble_seed),
    .poly(rx_descramble_polynomial),
    .in_data(rx_swap_data),
    .in_valid(rx_swap_valid),
    .out_data(rx_to_dec_data),
    .out_valid(rx_to_dec_valid)
  );

  lfsr_scrambler #(.W(16)) u_rx_post (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(rx_post_decode_descramble_on),
    .seed(rx_descramble_seed),
    .poly(rx_descramble_polynomial),
    .in_data(rx_from_dec_data),
    .in_valid(rx_from_dec_valid),
    .out_data(rx_out_data),
    .out_valid(rx_out_valid)
  );

endmodule : lane_char_scrambler_config

// File: verilog/lane_char_pkg.sv
// Shared constants for the lane character and scrambler configuration bank
package lane_char_pkg;

  localparam int CHAR_W = 10;
  localparam int REG_W = 16;
  localparam int EXT_REGS = 18;

  // Direct register indices; byte address is four times the index
  localparam logic [15:0] IDX_POINTER = 16'h001E;
  localparam logic [15:0] IDX_DATA = 16'h001F;
  localparam logic [31:0] ADDR_POINTER = {14'h0000, IDX_POINTER, 2'h0};
  localparam logic [31:0] ADDR_DATA = {14'h0000, IDX_DATA, 2'h0};
  localparam logic [15:0] POINTER_RESET = 16'h0000;

  // Slots of the extended register file
  localparam int S_TX_SEARCH = 0;
  localparam int S_TX_REPLACE = 1;
  localparam int S_RX_SEARCH = 2;
  localparam int S_RX_REPLACE = 3;
  localparam int S_TX_IDLE_P = 4;
  localparam int S_TX_IDLE_N = 5;
  localparam int S_RX_IDLE_P = 6;
  localparam int S_RX_IDLE_N = 7;
  localparam int S_TX_CTRL = 8;
  localparam int S_TX_SEED_HI = 9;
  localparam int S_TX_SEED_LO = 10;
  localparam int S_TX_POLY_HI = 11;
  localparam int S_TX_POLY_LO = 12;
  localparam int S_RX_CTRL = 13;
  localparam int S_RX_SEED_HI = 14;
  localparam int S_RX_SEED_LO = 15;
  localparam int S_RX_POLY_HI = 16;
  localparam int S_RX_POLY_LO = 17;

  localparam logic [15:0] EXT_OFFSET [EXT_REGS] = '{
    16'h8000, 16'h8001, 16'h8002, 16'h8003, 16'h8004, 16'h8005,
    16'h8006, 16'h8007, 16'h8009, 16'h800C, 16'h800D, 16'h800E,
    16'h800F, 16'h8019, 16'h801C, 16'h801D, 16'h801E, 16'h801F};

  localparam logic [15:0] EXT_RESET [EXT_REGS] = '{
    16'h02BC, 16'h027C, 16'h027C, 16'h02BC, 16'h02BC, 16'h02BC,
    16'h02BC, 16'h02BC, 16'hFC00, 16'h0000, 16'h01FC, 16'h0000,
    16'h00C0, 16'hFC00, 16'h0000, 16'h01FC, 16'h0000, 16'h00C0};

  // Writable bits; cleared bits read as zero
  localparam logic [15:0] EXT_MASK [EXT_REGS] = '{
    16'h03FF, 16'h03FF, 16'h03FF, 16'h03FF, 16'h03FF, 16'h03FF,
    16'h03FF, 16'h03FF, 16'hFFFF, 16'hFFFF, 16'hFFFE, 16'hFFFF,
    16'hFFFE, 16'hFFFF, 16'hFFFF, 16'hFFFE, 16'hFFFF, 16'hFFFE};

  localparam int CTRL_PRE_BIT = 0;
  localparam int CTRL_POST_BIT = 1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : lane_char_pkg

// File: verilog/lfsr_scrambler.sv
// Additive 32-bit LFSR scrambler, also used as descrambler
`timescale 1ns/1ps
module lfsr_scrambler #(
  parameter int W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic [31:0] seed,
  input wire logic [31:0] poly,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic [W-1:0] out_data,
  output logic out_valid
);
  logic [31:0] state_q;
  logic [31:0] state_d;
  logic [W-1:0] mixed;
  logic fb;

  // One LFSR step per data bit, lsb first
  always_comb begin
    state_d = state_q;
    mixed = in_data;
    fb = 1'b0;
    for (int i = 0; i < W; i++) begin
      fb = ^(state_d & poly);
      mixed[i] = in_data[i] ^ fb;
      state_d = {state_d[30:0], fb};
    end
  end

  // Held at the seed while off, so each enable restarts from it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= 32'h0000_0000;
    end else if (!enable) begin
      state_q <= seed;
    end else if (in_valid) begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_data <= '0;
      out_valid <= 1'b0;
    end else begin
      out_valid <= in_valid;
      out_data <= enable ? mixed : in_data;
    end
  end

endmodule : lfsr_scrambler

// File: verilog/marker_replacer.sv
// Swaps each matching 10-bit character of a word for a replacement
`timescale 1ns/1ps
module marker_replacer #(
  parameter int CHARS = 2,
  parameter int CW = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [CW-1:0] search,
  input wire logic [CW-1:0] replace,
  input wire logic [CHARS*CW-1:0] in_data,
  input wire logic in_valid,
  output logic [CHARS*CW-1:0] out_data,
  output logic out_valid
);
  logic [CHARS*CW-1:0] swapped;

  for (genvar g = 0; g < CHARS; g++) begin : g_char
    assign swapped[g*CW +: CW] =
      (in_data[g*CW +: CW] == search) ? replace : in_data[g*CW +: CW];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_data <= '0;
      out_valid <= 1'b0;
    end else begin
      out_valid <= in_valid;
      out_data <= swapped;
    end
  end

endmodule : marker_replacer

// File: sim/enc_dec_peer.sv
// Encoder and decoder stand-in facing the block's stream ports
`timescale 1ns/1ps
module enc_dec_peer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] tx_to_enc_data,
  input wire logic tx_to_enc_valid,
  output logic [19:0] tx_from_enc_data,
  output logic tx_from_enc_valid,
  input wire logic [19:0] rx_to_dec_data,
  input wire logic rx_to_dec_valid,
  output logic [15:0] rx_from_dec_data,
  output logic rx_from_dec_valid
);
  // Byte becomes char {2'b10, byte}; idle data shows the inverse of last
  always_ff @(posedge aclk) begin
    tx_from_enc_valid <= aresetn && tx_to_enc_valid;
    if (!aresetn) tx_from_enc_data <= 20'h00000;
    else if (tx_to_enc_valid) tx_from_enc_data <=
      {2'h2, tx_to_enc_data[15:8], 2'h2, tx_to_enc_data[7:0]};
    else tx_from_enc_data <= ~tx_from_enc_data;
  end
  always_ff @(posedge aclk) begin
    rx_from_dec_valid <= aresetn && rx_to_dec_valid;
    if (!aresetn) rx_from_dec_data <= 16'h0000;
    else if (rx_to_dec_valid) rx_from_dec_data <=
      {rx_to_dec_data[17:10], rx_to_dec_data[7:0]};
    else rx_from_dec_data <= ~rx_from_dec_data;
  end
endmodule : enc_dec_peer

// File: sim/lane_char_scrambler_config_props.sv
// Port checks for the character and scrambler bank
`timescale 1ns/1ps
module lane_char_scrambler_config_props #(
  parameter int ADDR_W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic tx_in_valid,
  input wire logic tx_to_enc_valid,
  input wire logic tx_from_enc_valid,
  input wire logic tx_line_valid,
  input wire logic rx_line_valid,
  input wire logic rx_to_dec_valid,
  input wire logic rx_from_dec_valid,
  input wire logic rx_out_valid,
  input wire logic [9:0] tx_idle_positive,
  input wire logic [9:0] tx_idle_negative,
  input wire logic [9:0] rx_idle_positive,
  input wire logic [9:0] rx_idle_negative
);
  wire aw_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire ok_w = s_axi_awaddr == lane_char_pkg::ADDR_POINTER ||
    s_axi_awaddr == lane_char_pkg::ADDR_DATA;
  wire ok_r = s_axi_araddr == lane_char_pkg::ADDR_POINTER ||
    s_axi_araddr == lane_char_pkg::ADDR_DATA;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  idle_tx_rst_a: assert property (!$past(aresetn) |->
    tx_idle_positive == 10'h2BC && tx_idle_negative == 10'h2BC)
    else $error("tx idle characters not at reset value");
  idle_rx_rst_a: assert property (!$past(aresetn) |->
    rx_idle_positive == 10'h2BC && rx_idle_negative == 10'h2BC)
    else $error("rx idle characters not at reset value");
  enc_lat_a: assert property (tx_in_valid |=> tx_to_enc_valid)
    else $error("encoder word missing one cycle after input");
  enc_only_a: assert property (tx_to_enc_valid |-> $past(tx_in_valid))
    else $error("encoder word without input word");
  line_lat_a: assert property (tx_from_enc_valid |-> ##2 tx_line_valid)
    else $error("line word missing two cycles after encoder");
  line_only_a: assert property (tx_line_valid |-> $past(tx_from_enc_valid, 2))
    else $error("line word without encoder word");
  dec_lat_a: assert property (rx_line_valid |-> ##2 rx_to_dec_valid)
    else $error("decoder word missing two cycles after line");
  out_lat_a: assert property (rx_from_dec_valid |=> rx_out_valid)
    else $error("user word missing one cycle after decoder");
  b_answer_a: assert property (aw_hs |=> ##1 s_axi_bvalid &&
    s_axi_bresp == ($past(ok_w, 2) ? lane_char_pkg::RESP_OKAY :
    lane_char_pkg::RESP_SLVERR))
    else $error("write response wrong or late");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not free after response");
  r_answer_a: assert property (ar_hs |=> s_axi_rvalid &&
    ($past(ok_r) ? s_axi_rresp == lane_char_pkg::RESP_OKAY :
    s_axi_rresp == lane_char_pkg::RESP_SLVERR && s_axi_rdata == 32'h0))
    else $error("read response wrong or late");
  cover property (tx_line_valid);
  cover property (rx_out_valid);
  cover property (s_axi_bvalid && s_axi_bresp == lane_char_pkg::RESP_SLVERR);
endmodule : lane_char_scrambler_config_props
bind lane_char_scrambler_config lane_char_scrambler_config_props
  #(.ADDR_W(ADDR_W)) props_i (.*);

// File: sim/test_lane_char_scrambler_config.sv
// Self-checking bench for the character and scrambler bank
`timescale 1ns/1ps
module test_lane_char_scrambler_config;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] tx_in_data, tx_to_enc_data, rx_from_dec_data, rx_out_data;
  logic [19:0] tx_from_enc_data, tx_line_data, rx_line_data, rx_to_dec_data;
  logic tx_in_valid, tx_to_enc_valid, tx_from_enc_valid, tx_line_valid;
  logic rx_line_valid, rx_to_dec_valid, rx_from_dec_valid, rx_out_valid;
  logic [9:0] tx_idle_positive, tx_idle_negative;
  logic [9:0] rx_idle_positive, rx_idle_negative;
  logic [39:0] idl;
  logic [19:0] q_enc[$], q_line[$], q_dec[$], q_out[$];
  logic [31:0] tx_seed;
  int fails, checks;
  assign idl = {rx_idle_negative, rx_idle_positive, tx_idle_negative,
    tx_idle_positive};
  lane_char_scrambler_config uut (.*);
  enc_dec_peer peer (.*);
  initial begin
    aclk = 0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (tx_to_enc_valid) q_enc.push_back({4'h0, tx_to_enc_data});
    if (tx_line_valid) q_line.push_back(tx_line_data);
    if (rx_to_dec_valid) q_dec.push_back(rx_to_dec_data);
    if (rx_out_valid) q_out.push_back({4'h0, rx_out_data});
  end
  task automatic chk(input logic [39:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
    bit ta, tw, tb;
    int n;
    n = 0;
    tb = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!tb && n < 100) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      n++;
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (tb) s_axi_bready <= 0;
    end
    if (!tb) fails++;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] d,
      output logic [1:0] r);
    bit ta, tb;
    int n;
    n = 0;
    tb = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (!tb && n < 100) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tb = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      n++;
      if (ta) s_axi_arvalid <= 0;
      if (tb) s_axi_rready <= 0;
    end
    if (!tb) fails++;
    @(posedge aclk);
  endtask : rd
  task automatic ext_wr(input logic [15:0] o, d);
    logic [1:0] r;
    wr(lane_char_pkg::ADDR_POINTER, {16'h0000, o}, r);
    chk(r, lane_char_pkg::RESP_OKAY);
    wr(lane_char_pkg::ADDR_DATA, {16'h0000, d}, r);
    chk(r, lane_char_pkg::RESP_OKAY);
  endtask : ext_wr
  task automatic ext_rd(input logic [15:0] o, output logic [31:0] d);
    logic [1:0] r;
    wr(lane_char_pkg::ADDR_POINTER, {16'h0000, o}, r);
    rd(lane_char_pkg::ADDR_DATA, d, r);
  endtask : ext_rd
  task automatic reg_test();
    logic [31:0] d;
    logic [15:0] o;
    logic [1:0] r;
    chk(idl, {4{10'h2BC}});
    for (int i = 0; i < lane_char_pkg::EXT_REGS; i++) begin
      o = lane_char_pkg::EXT_OFFSET[i];
      ext_rd(o, d);
      chk(d, {16'h0000, lane_char_pkg::EXT_RESET[i]});
      ext_wr(o, 16'hFFFF);
      ext_rd(o, d);
      chk(d, {16'h0000, lane_char_pkg::EXT_MASK[i]});
      if (i >= 4 && i <= 7) chk(idl[(i - 4) * 10 +: 10], 10'h3FF);
      ext_wr(o, lane_char_pkg::EXT_RESET[i]);
    end
    rd(lane_char_pkg::ADDR_POINTER, d, r);
    chk(d, 32'h0000801F);
    ext_wr(16'h8008, 16'hFFFF);
    ext_rd(16'h8008, d);
    chk(d, 32'h0);
    wr(32'h00000010, 32'h00000001, r);
    chk(r, lane_char_pkg::RESP_SLVERR);
    rd(32'h00000010, d, r);
    chk({r, d}, {lane_char_pkg::RESP_SLVERR, 32'h0});
    $display("register test done");
  endtask : reg_test
  function automatic logic [19:0] scr(input logic [19:0] d, input int w,
      inout logic [31:0] s, input logic [31:0] p);
    logic fb;
    for (int i = 0; i < w; i++) begin
      fb = ^(s & p);
      d[i] = d[i] ^ fb;
      s = {s[30:0], fb};
    end
    return d;
  endfunction : scr
  function automatic logic [19:0] repl(input logic [19:0] d,
      input logic [9:0] s, r);
    if (d[9:0] === s) d[9:0] = r;
    if (d[19:10] === s) d[19:10] = r;
    return d;
  endfunction : repl
  task automatic stream_test(input bit rx, input logic [15:0] ctrl,
      input logic [19:0] a, b);
    logic [31:0] s16, s20;
    logic [19:0] w[2];
    logic [19:0] e;
    s16 = rx ? 32'h00A51E5A : tx_seed;
    s20 = s16;
    w = '{a, b};
    ext_wr(rx ? 16'h8019 : 16'h8009, ctrl);
    if (rx) rx_line_data <= a;
    else tx_in_data <= a[15:0];
    if (rx) rx_line_valid <= 1;
    else tx_in_valid <= 1;
    @(posedge aclk);
    if (rx) rx_line_data <= b;
    else tx_in_data <= b[15:0];
    @(posedge aclk);
    rx_line_valid <= 0;
    tx_in_valid <= 0;
    rx_line_data <= ~b;
    tx_in_data <= ~b[15:0];
    repeat (8) @(posedge aclk);
    chk(q_enc.size() + q_line.size() + q_dec.size() + q_out.size(), 4);
    for (int k = 0; k < 2; k++) begin
      if (!rx) begin
        e = w[k] & 20'h0FFFF;
        if (ctrl[0]) e = scr(e, 16, s16, 32'h000000C0);
        chk(q_enc.pop_front(), e);
        e = {2'h2, e[15:8], 2'h2, e[7:0]};
        if (ctrl[1]) e = scr(e, 20, s20, 32'h000000C0);
        chk(q_line.pop_front(), repl(e, 10'h2BC, 10'h27C));
      end else begin
        e = repl(w[k], 10'h27C, 10'h2BC);
        if (ctrl[1]) e = scr(e, 20, s20, 32'h000000C0);
        chk(q_dec.pop_front(), e);
        e = {4'h0, e[17:10], e[7:0]};
        if (ctrl[0]) e = scr(e, 16, s16, 32'h000000C0);
        chk(q_out.pop_front(), e);
      end
    end
    ext_wr(rx ? 16'h8019 : 16'h8009, 16'hFC00);
    $display("stream test done rx=%0d ctrl=%h", rx, ctrl);
  endtask : stream_test
  task automatic end_of_test();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    #200000;
    fails++;
    end_of_test();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, tx_in_valid, rx_line_valid} = 4'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    {tx_in_data, rx_line_data} = 36'h0;
    s_axi_wstrb = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    reg_test();
    tx_seed = 32'h12345678;
    ext_wr(16'h800C, 16'h1234);
    ext_wr(16'h800D, 16'h5679);
    ext_wr(16'h801C, 16'h00A5);
    ext_wr(16'h801D, 16'h1E5B);
    stream_test(0, 16'hFC00, 20'h0BC12, 20'h012BC);
    stream_test(0, 16'hFC01, 20'h0A55A, 20'h0FFFF);
    stream_test(0, 16'hFC01, 20'h0A55A, 20'h0FFFF);
    stream_test(0, 16'hFC02, 20'h00F0F, 20'h0BCBC);
    stream_test(1, 16'hFC00, {10'h27C, 10'h101}, {10'h0AA, 10'h27C});
    stream_test(1, 16'hFC01, 20'h12345, 20'hABCDE);
    stream_test(1, 16'hFC02, 20'h9F27C, 20'h00001);
    end_of_test();
  end
endmodule : test_lane_char_scrambler_config
